// ===== hdl/diag_interrupt_section_builder.sv
// Purpose: builds the interrupt section of the slave diagnosis frame
// Assumes: event inputs come from logic on sys_clk, one-cycle pulses
// Notes: section bytes read out through a registered byte port
`timescale 1ns/1ps
`include "diag_irq_map.svh"

module diag_interrupt_section_builder
   import diag_irq_pkg::*;
#(
   // Identity byte of the base module and width of the entry count
   parameter logic [7:0] BASE_MODULE_ID = 8'h5a, // Arbitrary value
   parameter int CHAN_CNT_W = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   // Static configuration
   input wire logic layout_extended,
   // Diagnostic interrupt request
   input wire logic diag_req,
   input wire logic [7:0] diag_slot,
   input wire logic diag_from_fault_module, // Source is the fault-reporting expansion module
   input wire logic [127:0] diag_record,
   // Base module fault sources
   input wire logic base_general_err,
   input wire logic base_internal_err,
   input wire logic base_ext_cfg_err,
   input wire logic base_unreachable,
   input wire logic base_load_volt_err,
   input wire logic base_not_param,
   input wire logic base_param_err,
   input wire logic base_supply_low,
   input wire logic expansion_module_unaddressable,
   // Hardware interrupt request
   input wire logic hw_req,
   input wire logic [7:0] hw_slot,
   input wire logic [31:0] hw_info,
   // Frame side
   input wire logic [4:0] sect_rd_idx,
   output logic [7:0] sect_rd_data,
   output logic [7:0] sect_start,
   output logic [4:0] sect_len,
   output logic [1:0] sect_kind,
   output logic sect_valid,
   output logic [4:0] chan_err_type,
   output logic chan_err_valid
);

   // Section layout at the frame port, byte x+n
   // x+0 length in bytes, 20 for a diagnosis, 8 for hardware
   // x+1 kind code, 01 diagnostic and 02 hardware
   // x+2 slot number of the source
   // x+3 running count of accepted interrupts
   // Diagnosis from slot 02: base flags at x+4, the rest fixed
   // Diagnosis from any other slot: the sixteen record bytes
   // Hardware interrupt: four info bytes, x+4 to x+7
   // Bytes at or past the length read as zero

   // Reset release through two flops
   // Assertion acts at once; release waits two edges so that no
   // flop leaves reset a cycle ahead of its neighbours
   logic rst_meta;
   logic rst_sync;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // Section store and bookkeeping
   // Twenty bytes is the whole section, so nothing longer can be built
   logic [7:0] sect [0:19];
   logic [7:0] seq_num;
   irq_kind_t kind;

   // Software state
   // Control, count and mask written over the plain port and read back in their implemented bits only; status is set by events
   logic enh_en;
   logic [CHAN_CNT_W-1:0] chan_cnt;
   logic [`ST_WIDTH-1:0] status;
   logic [`ST_WIDTH-1:0] mask;

   // Base module byte x+4 in extended layout, a one marks a fault
   // Bits 0 to 4 general, internal, outside configuration,
   // unreachable modules and load voltage; bit 5 unused;
   // bit 6 module not parameterised, bit 7 parameter error
   function automatic logic [7:0] ext_flags();
      logic [7:0] f;
      f = 8'h00;
      f[0] = base_general_err;
      f[1] = base_internal_err;
      f[2] = base_ext_cfg_err;
      f[3] = base_unreachable;
      f[4] = base_load_volt_err;
      f[6] = base_not_param;
      f[7] = base_param_err;
      ext_flags = f;
   endfunction

   // Base module byte x+4 in compact layout, a one marks a fault
   // Bit 0 malfunction, bit 2 outside fault, bit 4 load supply,
   // bit 7 parameter error; bits 1, 3, 5 and 6 unused
   function automatic logic [7:0] cmp_flags();
      logic ext;
      logic load;
      logic malf;
      logic [7:0] f;
      ext = expansion_module_unaddressable;
      load = base_load_volt_err;
      // Low supply alone, or both outside faults together
      malf = base_supply_low | (ext & load);
      f = 8'h00;
      f[0] = malf;
      f[2] = ext;
      f[4] = load;
      f[7] = base_param_err;
      cmp_flags = f;
   endfunction

   // Start offset of the section in the frame
   // Enhanced frames push it behind the channel entries; the sum
   // wraps past byte 255, so counts above 79 are meaningless
   function automatic logic [7:0] start_of(
      input logic enh,
      input logic [CHAN_CNT_W-1:0] cnt
   );
      logic [15:0] off;
      off = 16'(`SECT_START_ENH) + 16'(cnt) * 16'(`CHAN_ENTRY_LEN);
      // Plain frames start right after the module diagnosis
      if (enh) begin
         start_of = off[7:0];
      end else begin
         start_of = `SECT_START_PLAIN;
      end
   endfunction

   // Diagnosis wins a tie; the hardware event is counted as lost
   // Only one interrupt fits a frame, and the diagnosis carries
   // more state, so the cheaper event gives way
   logic take_diag;
   logic take_hw;
   logic is_base;

   assign take_diag = diag_req;
   assign take_hw = hw_req & ~diag_req;
   // Only slot 02 gets the base module layouts
   assign is_base = (diag_slot == `BASE_SLOT);

   // Section contents; every new interrupt rebuilds all twenty bytes
   // Costs a wide write, but bytes that a shorter section leaves
   // behind can never show a stale value
   always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         for (int i = 0; i < 20; i++) begin
            sect[i] <= 8'h00;
         end
      end else if (take_diag) begin
         // Clear first so stale bytes never leak
         for (int i = 0; i < 20; i++) begin
            sect[i] <= 8'h00;
         end
         sect[0] <= {3'b000, `SECT_DIAG_LEN};
         sect[1] <= `KIND_CODE_DIAG;
         sect[2] <= diag_slot;
         sect[3] <= seq_num;
         if (is_base && layout_extended) begin
            sect[4] <= ext_flags();
            sect[5] <= `EXT_X5_FIXED;
            sect[8] <= BASE_MODULE_ID;
            sect[9] <= `EXT_X9_CHAN_LEN;
            sect[10] <= `EXT_X10_FIXED;
            // x+6, x+7 and x+11 on stay zero
         end else if (is_base) begin
            sect[4] <= cmp_flags();
            sect[5] <= {4'h0, `CMP_CLASS_CODE};
            // Upper nibble of x+5 is unassigned
         end else begin
            // Record byte i lands at x+4+i
            for (int i = 0; i < 16; i++) begin
               sect[`SECT_HDR_LEN - 1 + i] <= diag_record[8*i +: 8];
            end
         end
      end else if (take_hw) begin
         for (int i = 0; i < 20; i++) begin
            sect[i] <= 8'h00;
         end
         sect[0] <= {3'b000, `SECT_HW_LEN};
         sect[1] <= `KIND_CODE_HW;
         sect[2] <= hw_slot;
         sect[3] <= seq_num;
         // Info byte i lands at x+4+i; x+8 on stay zero
         for (int i = 0; i < 4; i++) begin
            sect[4 + i] <= hw_info[8*i +: 8];
         end
      end
   end

   // Kind, length and sequence number of the held interrupt
   // Length is four header bytes plus the payload of the kind
   // The count wraps from ff to 00; a poller only needs to see it move
   always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         kind <= KIND_NONE;
         sect_len <= 5'd0;
         seq_num <= 8'h00;
      end else if (take_diag) begin
         kind <= KIND_DIAG;
         sect_len <= `SECT_DIAG_LEN;
         seq_num <= seq_num + 8'h01;
      end else if (take_hw) begin
         kind <= KIND_HW;
         sect_len <= `SECT_HW_LEN;
         seq_num <= seq_num + 8'h01;
      end
   end

   assign sect_kind = kind;

   // Section position follows the live configuration
   // A new channel count moves a held section too, so software
   // rereads the offset after changing the count
   // Valid rises with the event itself, in the same cycle as the kind
   always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         sect_start <= `SECT_START_PLAIN;
         sect_valid <= 1'b0;
      end else begin
         sect_start <= start_of(enh_en, chan_cnt);
         sect_valid <= (kind != KIND_NONE) | take_diag | take_hw;
      end
   end

   // Channel error type for the fault-reporting expansion module
   // Held until the next diagnosis; hardware events leave it alone
   always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         chan_err_type <= 5'h00;
         chan_err_valid <= 1'b0;
      end else if (take_diag) begin
         // Type 11010 marks an external process fault
         chan_err_valid <= diag_from_fault_module;
         chan_err_type <= diag_from_fault_module ? `CHAN_ERR_EXT_FAULT : 5'h00;
      end
   end

   // Byte readout; index past the length reads zero
   // A master that sweeps all twenty bytes then never sees old data
   // The first guard keeps indices 20 to 31 off the end of the store
   always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         sect_rd_data <= 8'h00;
      end else if (sect_rd_idx < `SECT_MAX_LEN) begin
         sect_rd_data <= (sect_rd_idx < sect_len) ? sect[sect_rd_idx] : 8'h00;
      end else begin
         sect_rd_data <= 8'h00;
      end
   end

   // Register map on the plain port
   // 00 control, bit 0 enables enhanced diagnosis
   // 04 number of channel entries ahead of the section
   // 08 event status, cleared by its own read
   // 0c interrupt mask, same layout as status
   // 10 info: kind, length, count and start offset

   // Control and mask writes
   always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         enh_en <= 1'b0;
         chan_cnt <= CHAN_CNT_W'(`CHAN_CNT_RST);
         mask <= `ST_WIDTH'(`MASK_RST);
      end else if (reg_wr) begin
         case (reg_addr)
            `REG_CTRL: enh_en <= reg_wdata[`CTRL_ENH_BIT];
            `REG_CHAN_CNT: chan_cnt <= reg_wdata[CHAN_CNT_W-1:0];
            `REG_MASK: mask <= reg_wdata[`ST_WIDTH-1:0];
            // Unmapped offsets and the read-only words drop the write
            default: ;
         endcase
      end
   end

   // Sticky events; a set in the clearing cycle survives the clear
   // Bit 0 diagnosis taken, bit 1 hardware taken, bit 2 held
   // interrupt overwritten, bit 3 hardware lost to a diagnosis
   logic [`ST_WIDTH-1:0] events;
   logic [`ST_WIDTH-1:0] next_status;
   logic st_clr;

   always_comb begin
      events = '0;
      events[`ST_DIAG_BIT] = take_diag;
      events[`ST_HW_BIT] = take_hw;
      events[`ST_OVWR_BIT] = (take_diag | take_hw) & (kind != KIND_NONE);
      events[`ST_LOST_BIT] = diag_req & hw_req;
   end

   assign st_clr = reg_rd && (reg_addr == `REG_STATUS);

   // Next status, shared by the register and the interrupt pin
   always_comb begin
      next_status = (st_clr ? '0 : status) | events;
   end

   always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         status <= '0;
      end else begin
         status <= next_status;
      end
   end

   // Level interrupt while any unmasked bit stands
   // Taken from the next status so the pin keeps pace with the
   // register instead of trailing it by a cycle
   always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_status & mask);
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   // Zero outside the answer cycle keeps an OR of read buses clean
   // Reading status also clears it, in the sticky logic above
   always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `REG_CTRL: reg_rdata <= 32'(enh_en);
            `REG_CHAN_CNT: reg_rdata <= 32'(chan_cnt);
            `REG_STATUS: reg_rdata <= 32'(status);
            `REG_MASK: reg_rdata <= 32'(mask);
            `REG_INFO: reg_rdata <= {6'h00, kind, 3'b000, sect_len, seq_num, sect_start};
            default: reg_rdata <= 32'h0000_0000; // Unmapped reads zero
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule

// ===== hdl/diag_irq_map.svh
// Purpose: offsets, field positions, reset values and fixed codes
// Assumes: included by bare name
// Notes: definitions only
`ifndef DIAG_IRQ_MAP_SVH
`define DIAG_IRQ_MAP_SVH

// Register offsets on the plain port
`define REG_CTRL 8'h00
`define REG_CHAN_CNT 8'h04
`define REG_STATUS 8'h08
`define REG_MASK 8'h0c
`define REG_INFO 8'h10

// Control fields
`define CTRL_ENH_BIT 0
`define CTRL_RST 8'h00
`define CHAN_CNT_RST 8'h00
`define MASK_RST 8'h00

// Status and mask fields
`define ST_DIAG_BIT 0
`define ST_HW_BIT 1
`define ST_OVWR_BIT 2
`define ST_LOST_BIT 3
`define ST_WIDTH 4

// Section geometry in bytes
`define SECT_MAX_LEN 5'd20
`define SECT_DIAG_LEN 5'd20
`define SECT_HW_LEN 5'd8
`define SECT_HDR_LEN 5
`define SECT_START_PLAIN 8'd9
`define SECT_START_ENH 8'd16
`define CHAN_ENTRY_LEN 8'd3

// Header byte codes at x+1
`define KIND_CODE_NONE 8'h00
`define KIND_CODE_DIAG 8'h01
`define KIND_CODE_HW 8'h02

// Base module fixed values
`define BASE_SLOT 8'h02
`define EXT_X5_FIXED 8'h1b
`define EXT_X9_CHAN_LEN 8'h08
`define EXT_X10_FIXED 8'h08
`define CMP_CLASS_CODE 4'hb

// Channel error type for fault-reporting expansion module
`define CHAN_ERR_EXT_FAULT 5'h1a

`endif

// ===== hdl/diag_irq_pkg.sv
// Purpose: shared types of the interrupt section builder
// Assumes: nothing
// Notes: numbers live in diag_irq_map.svh
package diag_irq_pkg;
   typedef enum logic [1:0] {
      KIND_NONE,
      KIND_DIAG,
      KIND_HW
   } irq_kind_t;
endpackage

// ===== test/diag_section_checker_assertions.sv
// Purpose: port checks for the interrupt section builder
// Assumes: one clock, reset active low
// Notes: bound from the testbench top
`timescale 1ns/1ps

module diag_section_checker (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic diag_req,
   input wire logic hw_req,
   input wire logic diag_from_fault_module,
   input wire logic [7:0] sect_start,
   input wire logic [4:0] sect_len,
   input wire logic [1:0] sect_kind,
   input wire logic sect_valid,
   input wire logic [4:0] chan_err_type,
   input wire logic chan_err_valid
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // Length and kind follow the request one cycle later
   chk_len_cap: assert property (sect_len <= 5'd20)
      else $error("section longer than twenty bytes");
   chk_diag_wins: assert property (diag_req && hw_req |=> sect_kind == 2'd1)
      else $error("coincident hardware event displaced diagnosis");
   chk_start_pos: assert property (sect_start == 8'd9 ||
      (sect_start >= 8'd16 && (sect_start - 8'd16) % 8'd3 == 8'd0))
      else $error("section start off the entry grid");
   chk_hold_last: assert property (!diag_req && !hw_req |=> $stable(sect_len))
      else $error("section changed with no event");
   chk_valid_lag: assert property (diag_req || hw_req |-> ##2 sect_valid)
      else $error("section not flagged valid");
   chk_diag_len: assert property (diag_req |=> sect_len == 5'd20 && sect_kind == 2'd1)
      else $error("diagnostic section shape wrong");
   chk_hw_len: assert property (hw_req && !diag_req |=> sect_len == 5'd8 && sect_kind == 2'd2)
      else $error("hardware section shape wrong");
   chk_err_type: assert property (diag_req && diag_from_fault_module |=>
      chan_err_valid && chan_err_type == 5'h1a)
      else $error("channel error type not raised");
   chk_err_drop: assert property (diag_req && !diag_from_fault_module |=>
      !chan_err_valid)
      else $error("channel error type kept");

   // Main scenarios reached
   cov_fault_module: cover property (diag_req && diag_from_fault_module);
   cov_hw_only: cover property (hw_req && !diag_req);
   cov_both: cover property (diag_req && hw_req);
endmodule

// ===== test/dp_master_model.sv
// Purpose: polling master that reads the interrupt section
// Assumes: read data one cycle after the index
// Notes: sweeps all twenty bytes over and over
`timescale 1ns/1ps

module dp_master_model (
   input wire logic sys_clk,
   output logic [4:0] sect_rd_idx,
   input wire logic [7:0] sect_rd_data
);
   logic [7:0] image [0:19];
   logic [4:0] prev_idx;

   initial begin
      sect_rd_idx = 5'h00;
      prev_idx = 5'h00;
   end

   // Cyclic poll; the byte lands one cycle behind its index
   always @(posedge sys_clk) begin
      image[prev_idx] <= sect_rd_data;
      prev_idx <= sect_rd_idx;
      sect_rd_idx <= (sect_rd_idx == 5'd19) ? 5'h00 : sect_rd_idx + 5'd1;
   end
endmodule

// ===== test/tb_diag_interrupt_section_builder.sv
// Purpose: directed test of the interrupt section builder
// Assumes: section bytes come through the polling master model
// Notes: byte x+3 holds a sequence count and is not compared
`timescale 1ns/1ps
`include "diag_irq_map.svh"

module tb_diag_interrupt_section_builder;
   localparam logic [7:0] MOD_ID = 8'h3c; // Arbitrary value
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr, reg_rd, layout_extended, diag_req, diag_from_fault_module, hw_req, irq;
   logic base_general_err, base_internal_err, base_ext_cfg_err, base_unreachable;
   logic base_load_volt_err, base_not_param, base_param_err, base_supply_low;
   logic expansion_module_unaddressable, sect_valid, chan_err_valid;
   logic [7:0] reg_addr, diag_slot, hw_slot, sect_rd_data, sect_start;
   logic [31:0] reg_wdata, hw_info, reg_rdata;
   logic [127:0] diag_record;
   logic [4:0] sect_rd_idx, sect_len, chan_err_type;
   logic [1:0] sect_kind;
   logic [8:0] base_f;
   logic [159:0] exp_v;
   logic [8:0] cf [4] = '{9'h151, 9'h080, 9'h010, 9'h104};
   logic [7:0] cx [4] = '{8'h95, 8'h01, 8'h10, 8'h04};
   int error_cnt = 0;
   int tests_run = 0;

   // Fault sources driven as one vector
   assign {expansion_module_unaddressable, base_supply_low, base_param_err, base_not_param,
      base_load_volt_err, base_unreachable, base_ext_cfg_err, base_internal_err,
      base_general_err} = base_f;

   diag_interrupt_section_builder #(.BASE_MODULE_ID(MOD_ID)) dut (.sys_clk, .rst_n,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .layout_extended,
      .diag_req, .diag_slot, .diag_from_fault_module, .diag_record, .base_general_err,
      .base_internal_err, .base_ext_cfg_err, .base_unreachable, .base_load_volt_err,
      .base_not_param, .base_param_err, .base_supply_low, .expansion_module_unaddressable,
      .hw_req, .hw_slot, .hw_info, .sect_rd_idx, .sect_rd_data, .sect_start, .sect_len,
      .sect_kind, .sect_valid, .chan_err_type, .chan_err_valid);
   dp_master_model master (.sys_clk, .sect_rd_idx, .sect_rd_data);

   always #10 sys_clk = ~sys_clk;

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic read_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 cmp(reg_rdata, e);
   endtask

   task automatic fire(input logic d, input logic h);
      @(posedge sys_clk);
      diag_req <= d;
      hw_req <= h;
      @(posedge sys_clk);
      diag_req <= 1'b0;
      hw_req <= 1'b0;
   endtask

   // Wait for a full poll sweep, then compare every byte but the count
   task automatic img_chk();
      repeat (25) @(posedge sys_clk);
      for (int i = 0; i < 20; i++)
         if (i != 3)
            cmp(master.image[i], exp_v[8*i +: 8]);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      {reg_wr, reg_rd, diag_req, hw_req, diag_from_fault_module, layout_extended} = '0;
      {reg_addr, reg_wdata, diag_slot, hw_slot, hw_info, diag_record, base_f} = '0;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      cmp(sect_start, 8'd9);
      read_chk(8'h20, 32'h0);
      read_chk(`REG_MASK, 32'h0);
      bus_write(`REG_MASK, 32'hf);
      // Extended layout, base module slot
      layout_extended <= 1'b1;
      diag_slot <= 8'h02;
      base_f <= 9'h025;
      fire(1'b1, 1'b0);
      exp_v = {8'h08, 8'h08, MOD_ID, 16'h0, 8'h1b, 8'h45, 32'h00020114};
      img_chk();
      cmp(irq, 1'b1);
      read_chk(`REG_STATUS, 32'h1);
      @(posedge sys_clk);
      #1 cmp(irq, 1'b0);
      // Compact layout flag combinations
      layout_extended <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         base_f <= cf[k];
         fire(1'b1, 1'b0);
         exp_v = {8'h0b, cx[k], 32'h00020114};
         img_chk();
      end
      // Hardware event overwrites the held diagnosis
      hw_slot <= 8'h05;
      hw_info <= 32'h44332211;
      fire(1'b0, 1'b1);
      exp_v = {32'h44332211, 32'h00050208};
      img_chk();
      read_chk(`REG_STATUS, 32'h7);
      // Masked, coincident events from the fault-reporting module
      bus_write(`REG_MASK, 32'h0);
      diag_slot <= 8'h07;
      diag_from_fault_module <= 1'b1;
      diag_record <= 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
      fire(1'b1, 1'b1);
      exp_v = {128'hf0e1d2c3b4a5968778695a4b3c2d1e0f, 32'h00070114};
      img_chk();
      cmp(chan_err_type, 5'h1a);
      cmp(irq, 1'b0);
      read_chk(`REG_STATUS, 32'hd);
      // Enhanced diagnosis with three channel entries
      bus_write(`REG_CHAN_CNT, 32'h3);
      bus_write(`REG_CTRL, 32'h1);
      repeat (2) @(posedge sys_clk);
      #1 cmp(sect_start, 8'd25);
      read_chk(`REG_CTRL, 32'h1);
      read_chk(`REG_CHAN_CNT, 32'h3);
      read_chk(`REG_INFO, 32'h01140719);
      wrap_up();
   end

   // Whole run is a few hundred cycles
   initial begin
      repeat (3000) @(posedge sys_clk);
      error_cnt++;
      wrap_up();
   end
endmodule

bind diag_interrupt_section_builder diag_section_checker checker_i (.sys_clk, .rst_n,
   .diag_req, .hw_req, .diag_from_fault_module, .sect_start, .sect_len, .sect_kind,
   .sect_valid, .chan_err_type, .chan_err_valid);
